// >>> dv/core_model.sv
/*
   core model: issues port-read and power-down strobes on request.
   assumes its strobes are taken only while core reset is low.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic i_clk_sys,
   input  wire logic i_arst_n,
   input  wire logic i_core_reset,  // core held in reset
   input  wire logic i_go_sleep,    // bench asks for power-down
   input  wire logic i_go_read,     // bench asks for a port read
   input  wire logic i_read_first,  // read port just before sleep
   output var  logic o_port_access,
   output var  logic o_sleep_exec
);
   logic hold_q;  // sleep waiting behind the port read
   // one-cycle strobes, none while the core is held in reset
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_port_access <= 1'b0;
         o_sleep_exec  <= 1'b0;
         hold_q        <= 1'b0;
      end else begin
         o_port_access <= !i_core_reset & (i_go_read | (i_go_sleep & i_read_first));
         hold_q        <= !i_core_reset & i_go_sleep & i_read_first;
         o_sleep_exec  <= !i_core_reset & (hold_q | (i_go_sleep & !i_read_first));
      end
   end
endmodule : core_model
`default_nettype wire

// >>> dv/tb_sleep_wakeup_control.sv
/*
   self-checking bench: apb register access, sleep entry, watchdog,
   pin-change and master clear wakes with cause flags.
   assumes the design's short-count parameters are set here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wakeup_control_params.svh"
module tb_sleep_wakeup_control;
   localparam int DRT_POR = 20;   // short power-up delay
   localparam int DRT_RST = 10;   // short later-reset delay
   localparam int WDT_T   = 30;   // watchdog ticks to time-out
   localparam int LIMIT   = 6000; // run ceiling in cycles
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, r2;
   logic        clrwdt, fuse, master_clear_input_cfg, pa, pb, pc, port_acc, sleep_ex;
   logic [5:0]  core_out, core_oe, pin_out, pin_oe;
   logic        master_clear_input_out, master_clear_input_oe, osc_en, core_rst, asleep, to_f, pd_f, pwf;
   logic        go_sleep, go_read, rd_first, e;
   int          mismatches, n_tests, cyc_n, n;

   sleep_wakeup_control #(.DRT_POR_CYC(DRT_POR), .DRT_RST_CYC(DRT_RST), .WDT_TICKS(WDT_T)) dut (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_sleep_exec(sleep_ex),
      .i_clrwdt_exec(clrwdt), .i_port_access(port_acc), .i_watchdog_enable_fuse(fuse),
      .i_master_clear_input_config(master_clear_input_cfg), .i_wake_pin_a(pa), .i_wake_pin_b(pb),
      .i_multi_function_pin(pc), .i_core_pin_out(core_out), .i_core_pin_oe(core_oe),
      .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_master_clear_input_out(master_clear_input_out), .o_master_clear_input_oe(master_clear_input_oe),
      .o_osc_drive_en(osc_en), .o_core_reset(core_rst), .o_asleep(asleep),
      .o_time_out_flag(to_f), .o_power_down_flag(pd_f), .o_pin_wake_flag(pwf));

   core_model core (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_core_reset(core_rst), .i_go_sleep(go_sleep),
      .i_go_read(go_read), .i_read_first(rd_first), .o_port_access(port_acc),
      .o_sleep_exec(sleep_ex));

   // clock, 5 ns period
   always #2.5 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == LIMIT) begin
         mismatches++;
         conclude();
      end
   end

   // one comparison, reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // flags as time-out, power-down, pin-wake
   task automatic flags(input logic [2:0] exp);
      chk({29'h0, to_f, pd_f, pwf}, {29'h0, exp});
   endtask : flags

   task automatic rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask : rng

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : wait_cyc

   // apb transfer: setup, access, hold until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // ask the core model for power-down
   task automatic sleep_now(input logic rf);
      @(posedge clk);
      go_sleep <= 1'b1;
      rd_first <= rf;
      @(posedge clk);
      go_sleep <= 1'b0;
      wait_cyc(4);
   endtask : sleep_now

   // cycles until awake, bounded
   task automatic wait_wake(output int k);
      k = 0;
      while (asleep !== 1'b0 && k < 400) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_wake

   // cycles until core reset released, bounded
   task automatic wait_run(output int k);
      k = 0;
      while (core_rst !== 1'b0 && k < 100) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_run

   task automatic conclude();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
      pwdata = 32'h0; clrwdt = 0; fuse = 0; master_clear_input_cfg = 0; pa = 0; pb = 0;
      pc = 1; core_out = 6'h00; core_oe = 6'h00; go_sleep = 0; go_read = 0;
      rd_first = 1; mismatches = 0; n_tests = 0; cyc_n = 0;
      wait_cyc(4);
      arst_n <= 1'b1;
      // power-up: delay, flags, register port
      wait_run(n);
      rng(n, DRT_POR - 1, DRT_POR + 4);
      flags(3'b110);
      apb(1'b0, `SWC_OFS_STATUS, 32'h0, r, e);
      chk(r & 32'h99, 32'h18);
      apb(1'b1, `SWC_OFS_CTRL, 32'h1, r, e);
      apb(1'b0, `SWC_OFS_CTRL, 32'h0, r, e);
      chk(r, 32'h1);
      apb(1'b0, 8'h0c, 32'h0, r, e);
      chk({e, r[30:0]}, 32'h80000000);
      apb(1'b1, `SWC_OFS_CTRL, 32'h0, r, e);
      // watchdog wake from sleep
      core_out <= 6'h2a;
      core_oe  <= 6'h0f;
      fuse     <= 1'b1;
      sleep_now(1'b1);
      chk({30'h0, asleep, osc_en}, 32'h2);
      flags(3'b100);
      apb(1'b0, `SWC_OFS_WDT, 32'h0, r, e);
      chk({31'h0, r < 32'd4}, 32'h1);
      core_out <= 6'h15;
      core_oe  <= 6'h30;
      wait_cyc(20);
      chk({20'h0, pin_out, pin_oe}, {20'h0, 6'h2a, 6'h0f});
      apb(1'b0, `SWC_OFS_WDT, 32'h0, r2, e);
      chk({31'h0, r2 > r}, 32'h1);
      wait_wake(n);
      rng(n, 40, 4 * WDT_T);
      chk({28'h0, osc_en, core_rst, master_clear_input_oe, master_clear_input_out}, 32'hc);
      flags(3'b000);
      wait_run(n);
      rng(n, DRT_RST - 2, DRT_RST + 4);
      apb(1'b0, `SWC_OFS_WDT, 32'h0, r, e);
      chk({31'h0, r < 32'd8}, 32'h1);
      // clear-watchdog, then time-out while awake
      @(posedge clk);
      clrwdt <= 1'b1;
      @(posedge clk);
      clrwdt <= 1'b0;
      wait_cyc(2);
      flags(3'b110);
      n = 0;
      while (core_rst !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      rng(n, 4 * WDT_T - 8, 4 * WDT_T + 8);
      chk({31'h0, asleep}, 32'h0);
      wait_cyc(2);
      flags(3'b010);
      wait_run(n);
      fuse <= 1'b0;
      // pin-change wakes on each monitored pin
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `SWC_OFS_CTRL, 32'h1, r, e);
         sleep_now(1'b1);
         wait_cyc(i == 0 ? 200 : 10);
         chk({31'h0, asleep}, 32'h1);
         {pc, pb, pa} <= {pc, pb, pa} ^ (3'b001 << i);
         wait_wake(n);
         rng(n, 1, 8);
         flags(3'b101);
         wait_run(n);
      end
      // stale capture wakes at once
      @(posedge clk);
      go_read <= 1'b1;
      @(posedge clk);
      go_read <= 1'b0;
      pa      <= ~pa;
      apb(1'b1, `SWC_OFS_CTRL, 32'h1, r, e);
      sleep_now(1'b0);
      wait_wake(n);
      rng(n, 0, 6);
      flags(3'b101);
      wait_run(n);
      // master clear while awake, then from sleep
      apb(1'b1, `SWC_OFS_CTRL, 32'h0, r, e);
      pc       <= 1'b1;
      wait_cyc(4);
      master_clear_input_cfg <= 1'b1;
      wait_cyc(2);
      pc <= 1'b0;
      wait_cyc(5);
      chk({31'h0, core_rst}, 32'h1);
      pc <= 1'b1;
      wait_cyc(3);
      wait_run(n);
      flags(3'b101);
      sleep_now(1'b1);
      pc <= 1'b0;
      wait_cyc(5);
      chk({30'h0, asleep, core_rst}, 32'h1);
      pc <= 1'b1;
      wait_cyc(3);
      wait_run(n);
      flags(3'b100);
      // pin not configured as master clear: no wake
      master_clear_input_cfg <= 1'b0;
      sleep_now(1'b1);
      pc <= 1'b0;
      wait_cyc(10);
      chk({31'h0, asleep}, 32'h1);
      conclude();
   end
endmodule : tb_sleep_wakeup_control
`default_nettype wire

// >>> rtl/sleep_wakeup_control.sv
/*
   sleep and wake-up controller: power-down entry, watchdog, wake
   detection, reset delay timer and cause flags, apb register port.
   assumes the core pulses its sleep, clear-watchdog and port-access
   strobes for one cycle, and that i_clk_sys stands for the always
   running watchdog oscillator; o_osc_drive_en gates the core clock.
*/
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wakeup_control_params.svh"
module sleep_wakeup_control #(
   parameter int unsigned DRT_POR_CYC = `SWC_DRT_POR_CYC,
   parameter int unsigned DRT_RST_CYC = `SWC_DRT_RST_CYC,
   parameter int unsigned WDT_TICKS   = `SWC_WDT_TICKS
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,               // power-on reset
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pready,
   output var  logic        o_pslverr,
   input  wire logic        i_sleep_exec,           // power-down instruction
   input  wire logic        i_clrwdt_exec,          // clear-watchdog instruction
   input  wire logic        i_port_access,          // file or bit op on port
   input  wire logic        i_watchdog_enable_fuse,
   input  wire logic        i_master_clear_input_config,          // multi-function pin is master clear
   input  wire logic        i_wake_pin_a,
   input  wire logic        i_wake_pin_b,
   input  wire logic        i_multi_function_pin,
   input  wire logic [5:0]  i_core_pin_out,
   input  wire logic [5:0]  i_core_pin_oe,
   output var  logic [5:0]  o_pin_out,
   output var  logic [5:0]  o_pin_oe,
   output var  logic        o_master_clear_input_out,
   output var  logic        o_master_clear_input_oe,
   output var  logic        o_osc_drive_en,
   output var  logic        o_core_reset,
   output var  logic        o_asleep,
   output var  logic        o_time_out_flag,
   output var  logic        o_power_down_flag,
   output var  logic        o_pin_wake_flag
);
   sleep_wakeup_control_pkg::swc_state_t state_q, state_d;  // controller state
   logic [2:0]  pins_s;         // synchronised {c, b, a}
   logic [2:0]  snap_q;         // pins at last port access
   logic [1:0]  wd_div_q;       // watchdog oscillator divider
   logic [23:0] wdt_q;          // watchdog counter
   logic [23:0] drt_q;          // reset delay down-counter
   logic        woc_en_q;       // wake-on-change enable

   // pin synchroniser
   wake_pin_sync #(.WIDTH(3)) u_sync (
      .i_clk_sys   (i_clk_sys),
      .i_arst_n    (i_arst_n),
      .i_pins      ({i_multi_function_pin, i_wake_pin_b, i_wake_pin_a}),
      .o_pins_sync (pins_s)
   );

   // state decode
   wire st_run   = (state_q == sleep_wakeup_control_pkg::ST_RUN);
   wire st_sleep = (state_q == sleep_wakeup_control_pkg::ST_SLEEP);
   wire st_hold  = (state_q == sleep_wakeup_control_pkg::ST_HOLD);
   wire st_drt   = (state_q == sleep_wakeup_control_pkg::ST_DRT);

   // wake and reset sources
   wire wd_tick   = (wd_div_q == `SWC_WD_DIV_LAST);
   wire wdt_run   = i_watchdog_enable_fuse & (st_run | st_sleep);
   wire timeout   = wdt_run & wd_tick & (wdt_q == 24'(WDT_TICKS - 1));
   wire master_clear_input_low  = i_master_clear_input_config & ~pins_s[2];
   wire pin_diff  = woc_en_q & (pins_s != snap_q);
   wire drt_done  = st_drt & (drt_q <= 24'h1);

   // decoded events, master clear first, then watchdog, then pins
   wire ev_sleep      = st_run & ~master_clear_input_low & ~timeout & i_sleep_exec;
   wire ev_wdt        = ~master_clear_input_low & timeout;
   wire ev_pin        = st_sleep & ~master_clear_input_low & ~timeout & pin_diff;
   wire ev_master_clear_input_sleep = st_sleep & master_clear_input_low;
   wire ev_master_clear_input_awake = ~st_sleep & master_clear_input_low;
   wire ev_clrwdt     = st_run & ~master_clear_input_low & ~timeout & ~i_sleep_exec & i_clrwdt_exec;
   wire ev_wake       = st_sleep & (master_clear_input_low | timeout | pin_diff);
   wire wdt_clear     = ev_sleep | ev_wake | ev_clrwdt | ~wdt_run;

   // apb decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   wire        apb_acc  = i_psel & i_penable;
   wire        sel_ctrl = hit(i_paddr, `SWC_OFS_CTRL);
   wire        sel_stat = hit(i_paddr, `SWC_OFS_STATUS);
   wire        sel_wdt  = hit(i_paddr, `SWC_OFS_WDT);
   wire        unmapped = ~(sel_ctrl | sel_stat | sel_wdt);
   wire        wr_ctrl  = apb_acc & o_pready & i_pwrite & sel_ctrl;
   wire [31:0] stat_word = (32'(o_pin_wake_flag)   << `SWC_STAT_PWF_BIT)
                         | (32'(o_time_out_flag)   << `SWC_STAT_TO_BIT)
                         | (32'(o_power_down_flag) << `SWC_STAT_PD_BIT)
                         | (32'(st_sleep)          << `SWC_STAT_SLEEP_BIT);
   wire [31:0] rd_mux   = sel_ctrl ? (32'(woc_en_q) << `SWC_CTRL_WOC_BIT) :
                          sel_stat ? stat_word :
                          sel_wdt  ? {8'h00, wdt_q} : 32'h0000_0000;

   // next state: every wake leads through the reset delay
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sleep_wakeup_control_pkg::ST_RUN: begin
            if (master_clear_input_low)
               state_d = sleep_wakeup_control_pkg::ST_HOLD;
            else if (timeout)
               state_d = sleep_wakeup_control_pkg::ST_DRT;
            else if (i_sleep_exec)
               state_d = sleep_wakeup_control_pkg::ST_SLEEP;
         end
         sleep_wakeup_control_pkg::ST_SLEEP: begin
            if (master_clear_input_low)
               state_d = sleep_wakeup_control_pkg::ST_HOLD;
            else if (timeout || pin_diff)
               state_d = sleep_wakeup_control_pkg::ST_DRT;
         end
         sleep_wakeup_control_pkg::ST_HOLD: begin
            if (!master_clear_input_low)
               state_d = sleep_wakeup_control_pkg::ST_DRT;
         end
         sleep_wakeup_control_pkg::ST_DRT: begin
            if (master_clear_input_low)
               state_d = sleep_wakeup_control_pkg::ST_HOLD;
            else if (drt_done)
               state_d = sleep_wakeup_control_pkg::ST_RUN;
         end
      endcase
   end

   // state register and delay timer; power-up starts the long delay
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= sleep_wakeup_control_pkg::ST_DRT;
         drt_q   <= 24'(DRT_POR_CYC);
      end else begin
         state_q <= state_d;
         if (!st_drt && state_d == sleep_wakeup_control_pkg::ST_DRT)
            drt_q <= 24'(DRT_RST_CYC);
         else if (st_drt)
            drt_q <= drt_q - 24'h1;
      end
   end

   // watchdog oscillator divider and counter
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wd_div_q <= 2'h0;
         wdt_q    <= 24'h0;
      end else begin
         wd_div_q <= wd_div_q + 2'h1;
         if (wdt_clear || timeout)
            wdt_q <= 24'h0;
         else if (wd_tick)
            wdt_q <= wdt_q + 24'h1;
      end
   end

   // cause flags; power-up sets both time-out and power-down
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_time_out_flag   <= `SWC_TO_POR;
         o_power_down_flag <= `SWC_PD_POR;
         o_pin_wake_flag   <= `SWC_PWF_POR;
      end else if (ev_sleep) begin
         o_time_out_flag   <= 1'b1;
         o_power_down_flag <= 1'b0;
      end else if (ev_wdt) begin
         o_time_out_flag   <= 1'b0;
         o_pin_wake_flag   <= 1'b0;
         if (st_sleep)
            o_power_down_flag <= 1'b0;
      end else if (ev_pin) begin
         o_pin_wake_flag   <= 1'b1;
         o_time_out_flag   <= 1'b1;
         o_power_down_flag <= 1'b0;
      end else if (ev_master_clear_input_sleep) begin
         o_pin_wake_flag   <= 1'b0;
         o_time_out_flag   <= 1'b1;
         o_power_down_flag <= 1'b0;
      end else if (ev_clrwdt) begin
         o_time_out_flag   <= 1'b1;
         o_power_down_flag <= 1'b1;
      end
      // master clear while awake: flags untouched
   end

   // port snapshot for the change detector
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n)
         snap_q <= 3'h0;
      else if (i_port_access && st_run)
         snap_q <= pins_s;
   end

   // pin drivers frozen while asleep; master clear never driven
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pin_out  <= 6'h00;
         o_pin_oe   <= 6'h00;
         o_master_clear_input_out <= 1'b0;
         o_master_clear_input_oe  <= 1'b0;
      end else if (!st_sleep) begin
         o_pin_out  <= i_core_pin_out;
         o_pin_oe   <= i_core_pin_oe;
      end
   end

   // oscillator, core reset and sleep outputs
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_osc_drive_en <= 1'b1;
         o_core_reset   <= 1'b1;
         o_asleep       <= 1'b0;
      end else begin
         o_osc_drive_en <= (state_d != sleep_wakeup_control_pkg::ST_SLEEP);
         o_core_reset   <= (state_d != sleep_wakeup_control_pkg::ST_RUN);
         o_asleep       <= (state_d == sleep_wakeup_control_pkg::ST_SLEEP);
      end
   end

   // apb slave: one wait cycle, then pready with data
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
         woc_en_q  <= `SWC_CTRL_RST;
      end else begin
         o_pready  <= apb_acc & ~o_pready;
         o_pslverr <= apb_acc & ~o_pready & unmapped;
         if (apb_acc && !o_pready)
            o_prdata <= rd_mux;
         if (wr_ctrl)
            woc_en_q <= i_pwdata[`SWC_CTRL_WOC_BIT];
      end
   end

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   property p_sleep_by_instr;
      (!st_sleep ##1 st_sleep) |-> $past(i_sleep_exec);
   endproperty
   a_sleep_by_instr: assert property (p_sleep_by_instr) else $error("sleep without instruction");
   property p_wdt_clear_sleep;
      ev_sleep |=> (wdt_q == 24'h0) && st_sleep;
   endproperty
   a_wdt_clear_sleep: assert property (p_wdt_clear_sleep) else $error("watchdog not cleared");
   property p_flags_sleep;
      ev_sleep |=> o_time_out_flag && !o_power_down_flag;
   endproperty
   a_flags_sleep: assert property (p_flags_sleep) else $error("sleep flags wrong");
   property p_osc_off;
      ev_sleep |=> !o_osc_drive_en ##1 (!o_osc_drive_en || !st_sleep);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator not stopped");
   property p_pins_hold;
      st_sleep |=> $stable(o_pin_out) && $stable(o_pin_oe);
   endproperty
   a_pins_hold: assert property (p_pins_hold) else $error("pins moved in sleep");
   property p_master_clear_input_quiet;
      !o_master_clear_input_oe;
   endproperty
   a_master_clear_input_quiet: assert property (p_master_clear_input_quiet) else $error("master clear driven");
   property p_wdt_wake;
      (ev_wdt && st_sleep) |=> !o_time_out_flag && !o_power_down_flag && st_drt;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
   property p_pin_wake;
      ev_pin |=> o_pin_wake_flag && o_time_out_flag && !o_power_down_flag ##1 o_core_reset;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags wrong");
   property p_wake_clears;
      ev_wake |=> (wdt_q == 24'h0) && o_osc_drive_en;
   endproperty
   a_wake_clears: assert property (p_wake_clears) else $error("wake did not clear");
   property p_fuse_off;
      !i_watchdog_enable_fuse |-> !timeout && (wdt_q == 24'h0 || $past(i_watchdog_enable_fuse));
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("watchdog ran with fuse off");
   property p_master_clear_input_keeps;
      ev_master_clear_input_awake |=> $stable(o_time_out_flag) && $stable(o_power_down_flag)
                        && $stable(o_pin_wake_flag);
   endproperty
   a_master_clear_input_keeps: assert property (p_master_clear_input_keeps) else $error("master clear changed flags");

   c_pin_wake:  cover property (ev_pin);
   c_wdt_wake:  cover property (ev_wdt && st_sleep);
   c_master_clear_input_wake: cover property (ev_master_clear_input_sleep);
   c_drt_end:   cover property (drt_done ##1 st_run);
endmodule : sleep_wakeup_control
`default_nettype wire

// >>> rtl/sleep_wakeup_control_params.svh
/*
   offsets, field positions, reset values and timing counts of the
   sleep and wake-up controller.
   assumes a 200 MHz system clock and a 32-bit apb register port.
*/
`ifndef SLEEP_WAKEUP_CONTROL_PARAMS_SVH
`define SLEEP_WAKEUP_CONTROL_PARAMS_SVH

// register byte offsets
`define SWC_OFS_CTRL        8'h00
`define SWC_OFS_STATUS      8'h04
`define SWC_OFS_WDT         8'h08

// field positions
`define SWC_CTRL_WOC_BIT    0
`define SWC_STAT_PWF_BIT    7
`define SWC_STAT_TO_BIT     4
`define SWC_STAT_PD_BIT     3
`define SWC_STAT_SLEEP_BIT  0

// reset values
`define SWC_CTRL_RST        1'b0
`define SWC_TO_POR          1'b1
`define SWC_PD_POR          1'b1
`define SWC_PWF_POR         1'b0

// timing: times in ns, counts derived from the clock period
`define SWC_CLK_PERIOD_NS   5
`define SWC_DRT_POR_NS      18000000
`define SWC_DRT_RST_NS      300000
`define SWC_WDT_PERIOD_NS   18000000
`define SWC_WD_DIV          4
`define SWC_WD_DIV_LAST     2'h3
`define SWC_DRT_POR_CYC     ((`SWC_DRT_POR_NS + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
`define SWC_DRT_RST_CYC     ((`SWC_DRT_RST_NS + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
`define SWC_WDT_TICKS       (`SWC_WDT_PERIOD_NS / (`SWC_CLK_PERIOD_NS * `SWC_WD_DIV))

`endif

// >>> rtl/sleep_wakeup_control_pkg.sv
/*
   types of the sleep and wake-up controller.
   assumes nothing of its surroundings.
*/
`default_nettype none
package sleep_wakeup_control_pkg;
   // controller states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_HOLD,
      ST_DRT
   } swc_state_t;
endpackage : sleep_wakeup_control_pkg
`default_nettype wire

// >>> rtl/wake_pin_sync.sv
/*
   two-flop synchroniser for the monitored wake pins.
   assumes pins may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_pin_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_pins,
   output var  logic [WIDTH-1:0] o_pins_sync
);
   logic [WIDTH-1:0] meta_q;   // first stage, read only by second

   // two stages, constants under reset
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q      <= '0;
         o_pins_sync <= '0;
      end else begin
         meta_q      <= i_pins;
         o_pins_sync <= meta_q;
      end
   end
endmodule : wake_pin_sync
`default_nettype wire
